// ---- logic/twsio_pkg.sv ----
// Constants, types and register map of the three-wire serial block
package twsio_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_MODE   = 12'hFE0;
    localparam logic [11:0] ADDR_BUSCTL = 12'hFE2;
    localparam logic [11:0] ADDR_SHIFT  = 12'hFE4;
    localparam logic [11:0] ADDR_SVA    = 12'hFE6;
    localparam logic [11:0] ADDR_STAT   = 12'hFE8;
    localparam logic [7:0]  MODE_RST    = 8'h00;
    localparam logic [7:0]  BUSCTL_RST  = 8'h00;
    localparam logic [7:0]  MODE_BITOP  = 8'hE0;
    localparam logic [7:0]  MODE_STORE  = 8'hBF;
    localparam logic [7:0]  ALL_BITS    = 8'hFF;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MODE_EN_BIT    = 7;
    localparam int MODE_WUP_BIT   = 5;
    localparam int MODE_ORDER_BIT = 2;
    localparam int BUSCTL_BUS_RELEASE_TRIGGER    = 0;
    localparam int BUSCTL_COMMAND_TRIGGER    = 1;

    localparam logic [1:0] CLK_EXT   = 2'h0;
    localparam logic [1:0] CLK_TMR   = 2'h1;
    localparam logic [1:0] CLK_DIV16 = 2'h2;
    localparam logic [1:0] CLK_DIV8  = 2'h3;
    localparam logic [3:0] HALF_DIV16 = 4'h8;
    localparam logic [3:0] HALF_DIV8  = 4'h4;
    localparam logic [2:0] LAST_BIT   = 3'h7;

    localparam logic [1:0] BOP_BYTE = 2'h0;
    localparam logic [1:0] BOP_SET  = 2'h1;
    localparam logic [1:0] BOP_CLR  = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_RUN    = 2'b01,
        ST_MASKED = 2'b10
    } twsio_st_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
        logic [1:0]  bop;
        logic [2:0]  bsel;
    } twsio_req_t;

    typedef struct packed {
        logic sck_o;
        logic sck_oe_b;
        logic so_o;
        logic so_oe_b;
    } twsio_pins_t;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] busctl;
        logic [7:0] sr;
        logic [7:0] slave_address_register;
        logic       irq;
        logic       so_latch;
        twsio_st_t  st;
        logic [2:0] bit_cnt;
        logic [3:0] div_cnt;
        logic       gen_sck;
        logic       clk_prev;
        logic [7:0] rdata;
    } twsio_state_t;

endpackage

// ---- logic/twsio_core.sv ----
// Three-wire synchronous serial interface with register port
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module twsio_core (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    // Register port
    input  wire twsio_pkg::twsio_req_t bus_req,
    output logic [7:0]              rd_data,
    // Link pins
    input  wire logic               serial_clock_pin_i,
    input  wire logic               serial_in_pin,
    output twsio_pkg::twsio_pins_t  pins,
    // Port and timer side
    input  wire logic               clock_port_latch,
    input  wire logic               timer_event_output,
    output logic                    serial_irq_flag,
    output logic                    address_match_flag
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

    // Byte write of all eight bits, or single-bit set/clear limited to the bits in allow
    function automatic logic [7:0] apply_wr(input logic [7:0] old, input twsio_pkg::twsio_req_t rq,
                                            input logic [7:0] allow);
        logic [7:0] m;
        m = allow & (8'h01 << rq.bsel);
        case (rq.bop)
            twsio_pkg::BOP_BYTE: apply_wr = rq.wdata;
            twsio_pkg::BOP_SET:  apply_wr = old | m;
            twsio_pkg::BOP_CLR:  apply_wr = old & ~m;
            default:             apply_wr = old;
        endcase
    endfunction

    twsio_pkg::twsio_state_t s_q;
    twsio_pkg::twsio_state_t s_d;

    logic       en;
    logic [1:0] clksel;
    logic       lsb_first;
    logic       cur_clk;
    logic       fall;
    logic       rise;
    logic       running;
    logic       done;
    logic       match_now;
    logic       wr_shift;
    logic [3:0] half;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign en        = s_q.mode[twsio_pkg::MODE_EN_BIT];
    assign clksel    = s_q.mode[1:0];
    assign lsb_first = s_q.mode[twsio_pkg::MODE_ORDER_BIT];
    assign running   = (s_q.st == twsio_pkg::ST_RUN);
    assign half      = (clksel == twsio_pkg::CLK_DIV16) ? twsio_pkg::HALF_DIV16 : twsio_pkg::HALF_DIV8;
    assign match_now = (s_q.slave_address_register == s_q.sr);
    assign wr_shift  = bus_req.wr && (bus_req.addr == twsio_pkg::ADDR_SHIFT)
                       && (bus_req.bop == twsio_pkg::BOP_BYTE);

    always_comb begin
        case (clksel)
            twsio_pkg::CLK_EXT: cur_clk = serial_clock_pin_i;
            twsio_pkg::CLK_TMR: cur_clk = timer_event_output;
            default:            cur_clk = s_q.gen_sck;
        endcase
    end

    assign fall = running && s_q.clk_prev && !cur_clk;
    assign rise = running && !s_q.clk_prev && cur_clk;
    assign done = rise && (s_q.bit_cnt == twsio_pkg::LAST_BIT);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d          = s_q;
        s_d.rdata    = 8'h00;
        s_d.clk_prev = cur_clk;

        // Internal divider only runs inside a transfer, so the clock stops when masked
        if (running && clksel[1]) begin
            if (s_q.div_cnt <= 4'h1) begin
                s_d.gen_sck = ~s_q.gen_sck;
                s_d.div_cnt = half;
            end else begin
                s_d.div_cnt = s_q.div_cnt - 4'h1;
            end
        end

        if (fall) begin
            s_d.so_latch = s_q.sr[7];
        end
        if (rise) begin
            s_d.sr      = {s_q.sr[6:0], serial_in_pin};
            s_d.bit_cnt = s_q.bit_cnt + 3'h1;
        end
        if (done) begin
            s_d.st      = twsio_pkg::ST_MASKED;
            s_d.gen_sck = 1'b1;
            s_d.bit_cnt = 3'h0;
        end

        // Triggers act one cycle after the write and clear themselves
        if (s_q.busctl[twsio_pkg::BUSCTL_BUS_RELEASE_TRIGGER]) begin
            s_d.so_latch = 1'b1;
            s_d.busctl[twsio_pkg::BUSCTL_BUS_RELEASE_TRIGGER] = 1'b0;
        end
        if (s_q.busctl[twsio_pkg::BUSCTL_COMMAND_TRIGGER]) begin
            s_d.so_latch = 1'b0;
            s_d.busctl[twsio_pkg::BUSCTL_COMMAND_TRIGGER] = 1'b0;
        end

        // Disabled: counter cleared, no shifting, irq flag held
        if (!en) begin
            s_d.st      = twsio_pkg::ST_IDLE;
            s_d.bit_cnt = 3'h0;
            s_d.gen_sck = 1'b1;
            s_d.div_cnt = 4'h0;
        end

        // Register writes
        if (bus_req.wr) begin
            case (bus_req.addr)
                twsio_pkg::ADDR_MODE: begin
                    // Match bit is never stored
                    s_d.mode = apply_wr(s_q.mode, bus_req, twsio_pkg::MODE_BITOP)
                               & twsio_pkg::MODE_STORE;
                end
                twsio_pkg::ADDR_BUSCTL: begin
                    s_d.busctl = apply_wr(s_q.busctl, bus_req, twsio_pkg::ALL_BITS);
                end
                twsio_pkg::ADDR_SHIFT: begin
                    if (wr_shift) begin
                        // Bit order is set by mirroring the data, the shift path never changes
                        s_d.sr = lsb_first ? rev8(bus_req.wdata) : bus_req.wdata;
                        // Enable must already be set; a late enable never starts
                        if (en && (!running || cur_clk)) begin
                            s_d.st      = twsio_pkg::ST_RUN;
                            s_d.bit_cnt = 3'h0;
                            s_d.gen_sck = 1'b1;
                            s_d.div_cnt = half;
                        end
                    end
                end
                twsio_pkg::ADDR_SVA: begin
                    if (bus_req.bop == twsio_pkg::BOP_BYTE) begin
                        s_d.slave_address_register = bus_req.wdata;
                    end
                end
                twsio_pkg::ADDR_STAT: begin
                    s_d.irq = apply_wr({7'h00, s_q.irq}, bus_req, 8'h01) != 8'h00;
                end
                default: begin
                end
            endcase
        end

        // Completion beats a same-cycle software clear
        if (done && en && (!s_q.mode[twsio_pkg::MODE_WUP_BIT]
                           || (s_q.slave_address_register == {s_q.sr[6:0], serial_in_pin}))) begin
            s_d.irq = 1'b1;
        end

        // Register reads, data valid in the next cycle
        if (bus_req.rd) begin
            case (bus_req.addr)
                twsio_pkg::ADDR_MODE:   s_d.rdata = {s_q.mode[7], match_now, s_q.mode[5:0]};
                twsio_pkg::ADDR_BUSCTL: s_d.rdata = s_q.busctl;
                twsio_pkg::ADDR_SHIFT:  s_d.rdata = lsb_first ? rev8(s_q.sr) : s_q.sr;
                twsio_pkg::ADDR_STAT:   s_d.rdata = {7'h00, s_q.irq};
                default:                s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_q          <= '0;
            s_q.mode     <= twsio_pkg::MODE_RST;
            s_q.busctl   <= twsio_pkg::BUSCTL_RST;
            s_q.st       <= twsio_pkg::ST_IDLE;
            s_q.gen_sck  <= 1'b1;
            s_q.clk_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rd_data            = s_q.rdata;
    assign serial_irq_flag    = s_q.irq;
    assign address_match_flag = match_now;
    // Three lines only: clock, out, in
    assign pins.sck_oe_b = (clksel == twsio_pkg::CLK_EXT);
    assign pins.sck_o    = running ? cur_clk : clock_port_latch;
    assign pins.so_o     = s_q.so_latch;
    assign pins.so_oe_b  = !en;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence seq_last_rise;
        running && rise && (s_q.bit_cnt == twsio_pkg::LAST_BIT);
    endsequence
    sequence seq_bus_release_trigger_wr;
        bus_req.wr && (bus_req.addr == twsio_pkg::ADDR_BUSCTL) && (bus_req.bop == twsio_pkg::BOP_SET)
            && (bus_req.bsel == 3'h0);
    endsequence
    sequence seq_command_trigger_wr;
        bus_req.wr && (bus_req.addr == twsio_pkg::ADDR_BUSCTL) && (bus_req.bop == twsio_pkg::BOP_SET)
            && (bus_req.bsel == 3'h1);
    endsequence

    AST_RESET_ZERO: assert property ($rose(rst_b) |-> (s_q.mode == 8'h00) && (s_q.busctl == 8'h00))
        else $error("control registers not zero after reset");
    AST_MODE_LOW_BITOP: assert property (bus_req.wr && (bus_req.addr == twsio_pkg::ADDR_MODE)
            && (bus_req.bop != twsio_pkg::BOP_BYTE) && (bus_req.bsel < 3'h5) |=> $stable(s_q.mode[4:0]))
        else $error("low mode bit changed by bit access");
    AST_BUS_RELEASE_TRIGGER_SETS: assert property (seq_bus_release_trigger_wr ##1 !running |=> s_q.so_latch && !s_q.busctl[0])
        else $error("release trigger did not set out latch");
    AST_COMMAND_TRIGGER_CLEARS: assert property (seq_command_trigger_wr ##1 !running |=> !s_q.so_latch && !s_q.busctl[1])
        else $error("command trigger did not clear out latch");
    AST_LAST_MASKS: assert property (seq_last_rise |=> (s_q.st == twsio_pkg::ST_MASKED) ##1 !running)
        else $error("transfer did not stop after eighth bit");
    AST_IRQ_DONE: assert property (seq_last_rise ##0 en && !s_q.mode[twsio_pkg::MODE_WUP_BIT]
            |=> serial_irq_flag)
        else $error("irq flag not set on completion");
    AST_FALL_OUT: assert property (fall && !s_q.busctl[0] && !s_q.busctl[1]
            |=> s_q.so_latch == $past(s_q.sr[7]))
        else $error("out latch not updated on falling edge");
    AST_RISE_IN: assert property (rise && !wr_shift |=> s_q.sr[0] == $past(serial_in_pin))
        else $error("input not sampled on rising edge");
    AST_MATCH_READ: assert property (bus_req.rd && (bus_req.addr == twsio_pkg::ADDR_MODE)
            |=> rd_data[6] == $past(s_q.slave_address_register == s_q.sr))
        else $error("match flag read wrong");
    AST_NO_LATE_START: assert property (wr_shift && !en |=> !running)
        else $error("transfer started while disabled");
    AST_IDLE_START: assert property (wr_shift && en && !running |=> running && (s_q.bit_cnt == 3'h0))
        else $error("enabled write did not start transfer");
    AST_CLK_IDLE: assert property (!running && (clksel != twsio_pkg::CLK_EXT)
            |-> !pins.sck_oe_b && (pins.sck_o == clock_port_latch))
        else $error("internal clock pin idle level wrong");

endmodule

`default_nettype wire

// ---- tb/twsio_peer.sv ----
// Behavioural far-end partner on the three-wire serial link
`timescale 1ns/100ps
`default_nettype none

module twsio_peer (
    // Link lines
    input  wire logic       line_sck,
    input  wire logic       so_line,
    output logic            si_line,
    output logic            ext_sck,
    // Bench control
    input  wire logic       arm,
    input  wire logic       gen_clk,
    input  wire logic [7:0] tx_byte,
    output logic [7:0]      rx_byte,
    output logic            done
);
    int         cnt;
    logic [7:0] tx_q;

    initial begin
        cnt = 8;
        si_line = 1'b0;
        ext_sck = 1'b1;
        done = 1'b0;
        rx_byte = 8'h00;
        tx_q = 8'h00;
    end

    always @(posedge arm) begin
        cnt = 0;
        tx_q = tx_byte;
        done = 1'b0;
    end

    // Data moves on the falling edge, well clear of the rising sample
    // Outside a frame the line toggles so a stale bit never passes for data
    always @(negedge line_sck) begin
        if (cnt < 8) si_line = tx_q[7 - cnt];
        else si_line = ~si_line;
    end

    always @(posedge line_sck) begin
        if (cnt < 8) begin
            rx_byte = {rx_byte[6:0], so_line};
            cnt++;
            done = (cnt == 8);
            // Flip only after the block has sampled the last bit
            if (done) si_line <= #60 ~si_line;
        end
    end

    // External clock idles high and runs only for one eight-bit frame
    always @(posedge gen_clk) begin
        // Half-cycle offset keeps every edge off the sampling clock edge
        #20;
        repeat (8) begin
            #200 ext_sck = 1'b0;
            #200 ext_sck = 1'b1;
        end
    end

endmodule
`default_nettype wire

// ---- tb/tb_twsio_core.sv ----
// Self-checking bench for the three-wire serial block
`timescale 1ns/100ps
`default_nettype none

module tb_twsio_core;
    logic                   clk_sys, rst_b, clock_port_latch, arm, gen_clk, rd_seen;
    twsio_pkg::twsio_req_t  bus_req;
    twsio_pkg::twsio_pins_t pins;
    logic [7:0]             rd_data, tx, d, peer_rx;
    logic                   serial_irq_flag, address_match_flag, si, ext_sck, peer_done;
    wire logic              line_sck;
    logic [7:0]             exp_q[$];
    integer                 err_count, tests_run, seed;

    assign line_sck = pins.sck_oe_b ? ext_sck : pins.sck_o;

    twsio_core twsio_core_i (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
        .serial_clock_pin_i(ext_sck), .serial_in_pin(si), .pins(pins), .clock_port_latch(clock_port_latch),
        .timer_event_output(ext_sck), .serial_irq_flag(serial_irq_flag), .address_match_flag(address_match_flag));

    twsio_peer twsio_peer_i (.line_sck(line_sck), .so_line(pins.so_o), .si_line(si), .ext_sck(ext_sck),
        .arm(arm), .gen_clk(gen_clk), .tx_byte(tx), .rx_byte(peer_rx), .done(peer_done));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (rd_seen) check("rd_data", rd_data, exp_q.pop_front());
        rd_seen <= bus_req.rd;
    end

    task automatic bw(input logic [11:0] a, input logic [7:0] v, input logic [1:0] op, input logic [2:0] b);
        @(posedge clk_sys);
        bus_req.addr <= a;
        bus_req.wdata <= v;
        bus_req.bop <= op;
        bus_req.bsel <= b;
        bus_req.wr <= 1'b1;
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        bw(a, v, twsio_pkg::BOP_BYTE, 3'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        @(posedge clk_sys);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
    endtask

    task automatic wait_irq;
        int n;
        for (n = 0; n < 3000 && serial_irq_flag !== 1'b1; n++) @(negedge clk_sys);
        if (n == 3000) begin
            err_count++;
            $display("[ERR] serial_irq_flag expected 1 seen timeout");
            give_verdict;
        end
        repeat (2) @(negedge clk_sys);
    endtask

    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
    endfunction

    // One full frame with the given clock source and bit order
    task automatic xfer(input logic [1:0] sel, input logic lsb);
        tx = 8'($random(seed));
        d = 8'($random(seed));
        wr(twsio_pkg::ADDR_MODE, {3'b100, 2'b00, lsb, sel});
        wr(twsio_pkg::ADDR_SVA, tx);
        wr(twsio_pkg::ADDR_STAT, 8'h00);
        @(posedge clk_sys);
        arm <= 1'b1;
        @(posedge clk_sys);
        arm <= 1'b0;
        wr(twsio_pkg::ADDR_SHIFT, d);
        if (sel == twsio_pkg::CLK_EXT || sel == twsio_pkg::CLK_TMR) begin
            gen_clk <= 1'b1;
            @(posedge clk_sys);
            gen_clk <= 1'b0;
        end
        wait_irq;
        check("peer_rx", peer_rx, lsb ? rev8(d) : d);
        check("peer_done", {7'h00, peer_done}, 8'h01);
        check("sck_oe_b", {7'h00, pins.sck_oe_b}, {7'h00, sel == twsio_pkg::CLK_EXT});
        check("match", {7'h00, address_match_flag}, 8'h01);
        rd(twsio_pkg::ADDR_SHIFT, lsb ? rev8(tx) : tx);
        rd(twsio_pkg::ADDR_STAT, 8'h01);
        rd(twsio_pkg::ADDR_MODE, {3'b110, 2'b00, lsb, sel});
        $display("test frame sel %0d lsb %0d done", sel, lsb);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h8C60;
        err_count = 0;
        tests_run = 0;
        rst_b = 1'b0;
        bus_req = '0;
        clock_port_latch = 1'b1;
        arm = 1'b0;
        gen_clk = 1'b0;
        rd_seen = 1'b0;
        tx = 8'h00;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        // Shift and address registers both clear, so the match bit reads 1
        rd(twsio_pkg::ADDR_MODE, twsio_pkg::MODE_RST | 8'h40);
        rd(twsio_pkg::ADDR_BUSCTL, twsio_pkg::BUSCTL_RST);
        rd(12'hFFE, 8'h00);
        $display("test reset done");
        wr(twsio_pkg::ADDR_MODE, 8'h03);
        wr(twsio_pkg::ADDR_SHIFT, 8'hA5);
        @(negedge clk_sys);
        check("so_oe_b", {7'h00, pins.so_oe_b}, 8'h01);
        wr(twsio_pkg::ADDR_MODE, 8'h83);
        repeat (100) @(negedge clk_sys);
        check("irq", {7'h00, serial_irq_flag}, 8'h00);
        check("sck_o", {7'h00, pins.sck_o}, 8'h01);
        $display("test late enable done");
        for (int s = 0; s < 4; s++) xfer(2'(s), 1'b0);
        xfer(twsio_pkg::CLK_DIV8, 1'b1);
        wr(twsio_pkg::ADDR_SVA, ~tx);
        @(negedge clk_sys);
        check("match", {7'h00, address_match_flag}, 8'h00);
        // Triggers fired only between frames
        bw(twsio_pkg::ADDR_BUSCTL, 8'h00, twsio_pkg::BOP_SET, 3'(twsio_pkg::BUSCTL_BUS_RELEASE_TRIGGER));
        repeat (2) @(negedge clk_sys);
        check("so_o", {7'h00, pins.so_o}, 8'h01);
        rd(twsio_pkg::ADDR_BUSCTL, 8'h00);
        bw(twsio_pkg::ADDR_BUSCTL, 8'h00, twsio_pkg::BOP_SET, 3'(twsio_pkg::BUSCTL_COMMAND_TRIGGER));
        repeat (2) @(negedge clk_sys);
        check("so_o", {7'h00, pins.so_o}, 8'h00);
        rd(twsio_pkg::ADDR_BUSCTL, 8'h00);
        $display("test triggers done");
        bw(twsio_pkg::ADDR_MODE, 8'h00, twsio_pkg::BOP_CLR, 3'(twsio_pkg::MODE_EN_BIT));
        // Low mode bits refuse single-bit access
        bw(twsio_pkg::ADDR_MODE, 8'h00, twsio_pkg::BOP_CLR, 3'h0);
        rd(twsio_pkg::ADDR_MODE, 8'h07);
        @(negedge clk_sys);
        check("so_oe_b", {7'h00, pins.so_oe_b}, 8'h01);
        // Match bit written as 1 must not stick
        wr(twsio_pkg::ADDR_MODE, 8'hC3);
        @(posedge clk_sys);
        clock_port_latch <= 1'b0;
        @(negedge clk_sys);
        check("sck_o", {7'h00, pins.sck_o}, 8'h00);
        rd(twsio_pkg::ADDR_MODE, 8'h83);
        $display("test idle clock done");
        repeat (4) @(posedge clk_sys);
        give_verdict;
    end

endmodule
`default_nettype wire
